// [verilog/utxd_pkg.sv]
// constants shared by the transmit descriptor dma engine and its helpers
package utxd_pkg;
   localparam int NCH = 4;
   localparam int CHW = 2;
   localparam int NSTAT = NCH + 1;
   // ----------------------------------------------------------------
   // per-channel state words (index within a channel block)
   // ----------------------------------------------------------------
   localparam logic [2:0] W_HEAD = 3'h0;
   localparam logic [2:0] W_SOP = 3'h1;
   localparam logic [2:0] W_CDESC = 3'h2;
   localparam logic [2:0] W_CBUF = 3'h3;
   localparam logic [2:0] W_SCRATCH = 3'h4;
   localparam logic [2:0] W_LEN = 3'h5;
   localparam logic [2:0] W_COMP = 3'h6;
   localparam logic [2:0] W_RECEIVE_BUFFER_COUNT = 3'h7;
   localparam logic [31:0] STATE_RESET = 32'h0;
   // ----------------------------------------------------------------
   // global registers (byte addresses, bit 7 set)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_STATUS = 8'h80;
   localparam logic [7:0] ADR_ENABLE = 8'h84;
   localparam logic [7:0] ADR_CLEAR = 8'h88;
   localparam logic [7:0] ADR_CTRL = 8'h8c;
   localparam logic [31:0] CTRL_RESET = 32'h0;
   localparam int CTRL_EN_BIT = 0;
   // ----------------------------------------------------------------
   // descriptor layout
   // ----------------------------------------------------------------
   localparam logic [31:0] DW_NEXT = 32'h0;
   localparam logic [31:0] DW_CTL = 32'hc;
   localparam int SOP_BIT = 31;
   localparam int EOP_BIT = 30;
   localparam int OWN_BIT = 29;
   localparam int EOQ_BIT = 28;
   localparam int ZLP_BIT = 23;
   localparam int RXAB_BIT = 19;
   // ----------------------------------------------------------------
   // engine states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      S_IDLE = 4'h0,
      S_RD = 4'h1,
      S_EVAL = 4'h3,
      S_BRD = 4'h2,
      S_BOUT = 4'h6,
      S_WEOQ = 4'h7,
      S_WOWN = 4'h5,
      S_DONE = 4'h4,
      S_ABRD = 4'hc,
      S_ABWR = 4'hd
   } utxd_state_t;
endpackage : utxd_pkg

// [verilog/utxd_chan_regs.sv]
// state word bank of one transmit channel
`timescale 1ns/1ps
`default_nettype none
module utxd_chan_regs (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // software side
   input wire logic i_sw_we,
   input wire logic [2:0] i_sw_idx,
   input wire logic [31:0] i_sw_dat,
   input wire logic [3:0] i_sw_sel,
   // engine side, wins over software in the same cycle
   input wire logic [7:0] i_hw_we,
   input wire logic [7:0][31:0] i_hw_dat,
   // contents
   output logic [7:0][31:0] o_words
);
   wire [31:0] mask = {{8{i_sw_sel[3]}}, {8{i_sw_sel[2]}}, {8{i_sw_sel[1]}}, {8{i_sw_sel[0]}}};
   genvar w;
   generate
      for (w = 0; w < 8; w++) begin : g_word
         wire sw_hit = i_sw_we && (i_sw_idx == 3'(w));
         wire [31:0] merged = (o_words[w] & ~mask) | (i_sw_dat & mask);
         always_ff @(posedge i_clk) begin
            if (i_reset)
               o_words[w] <= utxd_pkg::STATE_RESET;
            else if (i_hw_we[w])
               o_words[w] <= i_hw_dat[w];
            else if (sw_hit)
               o_words[w] <= merged;
         end
      end
   endgenerate
endmodule : utxd_chan_regs
`default_nettype wire

// [verilog/utxd_irq.sv]
// sticky event status, enable and one level interrupt
`timescale 1ns/1ps
`default_nettype none
module utxd_irq #(
   parameter int W = 5
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // events and clears
   input wire logic [W-1:0] i_set,
   input wire logic [W-1:0] i_clr,
   // enable register write
   input wire logic i_en_we,
   input wire logic [W-1:0] i_en_dat,
   // state
   output logic [W-1:0] o_status,
   output logic [W-1:0] o_enable,
   output logic o_irq
);
   // set wins so an event in the clearing cycle is kept
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_status <= '0;
         o_enable <= '0;
      end else begin
         o_status <= (o_status & ~i_clr) | i_set;
         if (i_en_we)
            o_enable <= i_en_dat;
      end
   end
   assign o_irq = |(o_status & o_enable);
endmodule : utxd_irq
`default_nettype wire

// [verilog/utxd_top.sv]
// transmit descriptor walking dma engine with wishbone register slave
`timescale 1ns/1ps
`default_nettype none
module utxd_top (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset,
   // wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [31:0] i_wb_dat,
   input wire logic [3:0] i_wb_sel,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // descriptor and buffer memory port
   output logic o_mem_req,
   output logic o_mem_we,
   output logic [31:0] o_mem_addr,
   output logic [31:0] o_mem_wdata,
   input wire logic i_mem_ack,
   input wire logic [31:0] i_mem_rdata,
   // endpoint fifo byte stream
   output logic o_fifo_valid,
   output logic [7:0] o_fifo_data,
   output logic o_fifo_last,
   output logic o_fifo_zlp,
   output logic [utxd_pkg::CHW-1:0] o_fifo_ch,
   input wire logic i_fifo_ready,
   // receive abort request
   input wire logic i_rx_abort,
   input wire logic [utxd_pkg::CHW-1:0] i_rx_abort_ch,
   input wire logic [31:0] i_rx_abort_sop,
   output logic [utxd_pkg::NCH-1:0] o_rx_enable,
   // interrupt
   output logic o_irq
);
   // ----------------------------------------------------------------
   // wishbone decode
   // ----------------------------------------------------------------
   wire wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
   wire wb_wr = wb_req && i_wb_we;
   wire adr_is_ch = !i_wb_adr[7];
   wire [utxd_pkg::CHW-1:0] adr_ch = i_wb_adr[6:5];
   wire [2:0] adr_word = i_wb_adr[4:2];
   wire wr_enable = wb_wr && (i_wb_adr == utxd_pkg::ADR_ENABLE);
   wire wr_clear = wb_wr && (i_wb_adr == utxd_pkg::ADR_CLEAR);
   wire wr_ctrl = wb_wr && (i_wb_adr == utxd_pkg::ADR_CTRL);
   wire [31:0] sel_mask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};

   typedef logic [utxd_pkg::CHW-1:0] utxd_chw_t;
   logic [utxd_pkg::NCH-1:0][7:0][31:0] words;
   logic [utxd_pkg::NCH-1:0] hw_sel;
   logic [7:0] hw_we;
   logic [7:0][31:0] hw_dat;
   logic [31:0] ctrl;
   logic [utxd_pkg::NSTAT-1:0] status;
   logic [utxd_pkg::NSTAT-1:0] enable;
   logic [utxd_pkg::NSTAT-1:0] ev_set;
   logic [utxd_pkg::NSTAT-1:0] comp_match;
   logic [utxd_pkg::NCH-1:0] ev_done;
   logic ev_ab;

   // ----------------------------------------------------------------
   // per-channel state banks
   // ----------------------------------------------------------------
   genvar c;
   generate
      for (c = 0; c < utxd_pkg::NCH; c++) begin : g_ch
         wire sw_we = wb_wr && adr_is_ch && (adr_ch == utxd_chw_t'(c));
         // a completion write that matches drops the channel interrupt
         assign comp_match[c] = sw_we && (adr_word == utxd_pkg::W_COMP)
                                && (i_wb_dat == words[c][utxd_pkg::W_COMP]);
         assign o_rx_enable[c] = words[c][utxd_pkg::W_RECEIVE_BUFFER_COUNT] != 32'h0;
         utxd_chan_regs u_regs (
            .i_clk(i_clk),
            .i_reset(i_reset),
            .i_sw_we(sw_we),
            .i_sw_idx(adr_word),
            .i_sw_dat(i_wb_dat),
            .i_sw_sel(i_wb_sel),
            .i_hw_we(hw_sel[c] ? hw_we : 8'h00),
            .i_hw_dat(hw_dat),
            .o_words(words[c])
         );
      end
   endgenerate
   assign comp_match[utxd_pkg::NCH] = 1'b0;

   utxd_irq #(
      .W(utxd_pkg::NSTAT)
   ) u_irq (
      .i_clk(i_clk),
      .i_reset(i_reset),
      .i_set(ev_set),
      .i_clr((wr_clear ? i_wb_dat[utxd_pkg::NSTAT-1:0] : '0) | comp_match),
      .i_en_we(wr_enable),
      .i_en_dat(i_wb_dat[utxd_pkg::NSTAT-1:0]),
      .o_status(status),
      .o_enable(enable),
      .o_irq(o_irq)
   );

   // ----------------------------------------------------------------
   // register read mux and ack
   // ----------------------------------------------------------------
   wire [31:0] glob_rd = (i_wb_adr == utxd_pkg::ADR_STATUS) ? 32'(status) :
                         (i_wb_adr == utxd_pkg::ADR_ENABLE) ? 32'(enable) :
                         (i_wb_adr == utxd_pkg::ADR_CTRL) ? ctrl : 32'h0;
   wire [31:0] rd_data = adr_is_ch ? words[adr_ch][adr_word] : glob_rd;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_wb_ack <= 1'b0;
         o_wb_dat <= 32'h0;
         ctrl <= utxd_pkg::CTRL_RESET;
      end else begin
         o_wb_ack <= wb_req;
         o_wb_dat <= wb_req ? rd_data : 32'h0;
         if (wr_ctrl)
            ctrl <= (ctrl & ~sel_mask) | (i_wb_dat & sel_mask);
      end
   end

   // ----------------------------------------------------------------
   // descriptor engine
   // ----------------------------------------------------------------
   utxd_pkg::utxd_state_t st;
   logic [utxd_pkg::CHW-1:0] ch;
   logic [utxd_pkg::CHW-1:0] rr;
   logic [1:0] widx;
   logic first;
   logic [31:0] d_next;
   logic [31:0] d_buf;
   logic [31:0] d_len;
   logic [31:0] d_ctl;
   logic [31:0] sop_ptr;
   logic [31:0] sop_ctl;
   logic [31:0] cur_desc;
   logic [31:0] cur_buf;
   logic [15:0] buf_left;
   logic [15:0] rem;
   logic [15:0] act;
   logic ab_pend;
   logic [utxd_pkg::CHW-1:0] ab_ch;
   logic [31:0] ab_addr;

   wire [31:0] rr_head = words[rr][utxd_pkg::W_HEAD];
   wire ports_on = ctrl[utxd_pkg::CTRL_EN_BIT];
   wire start_ok = d_ctl[utxd_pkg::SOP_BIT] && d_ctl[utxd_pkg::OWN_BIT];
   wire is_zlp = d_ctl[utxd_pkg::ZLP_BIT];
   wire [15:0] sop_left = d_len[15:0] - d_len[31:16];
   wire buf_done = (buf_left == 16'h0) || (rem == 16'h0);
   wire pkt_end = d_ctl[utxd_pkg::EOP_BIT] || (d_next == 32'h0);
   wire [7:0] rd_byte = 8'(i_mem_rdata >> {cur_buf[1:0], 3'b000});
   wire [31:0] eoq_keep = 32'((sop_ptr == cur_desc) && (d_next == 32'h0)) << utxd_pkg::EOQ_BIT;
   wire [31:0] own_clr = (sop_ctl & ~(32'h1 << utxd_pkg::OWN_BIT)) | eoq_keep;
   wire ab_hit = i_rx_abort && !ab_pend
                 && (words[i_rx_abort_ch][utxd_pkg::W_RECEIVE_BUFFER_COUNT] != 32'h0);

   assign ev_set = {ev_ab, ev_done};
   assign o_fifo_ch = ch;

   generate
      for (c = 0; c < utxd_pkg::NCH; c++) begin : g_hwsel
         assign hw_sel[c] = (ch == utxd_chw_t'(c));
      end
   endgenerate

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st <= utxd_pkg::S_IDLE;
         ch <= '0;
         rr <= '0;
         widx <= 2'h0;
         first <= 1'b0;
         {d_next, d_buf, d_len, d_ctl} <= '0;
         {sop_ptr, sop_ctl, cur_desc, cur_buf} <= '0;
         {buf_left, rem, act} <= '0;
         {ab_pend, ab_ch, ab_addr} <= '0;
         {o_mem_req, o_mem_we, o_mem_addr, o_mem_wdata} <= '0;
         {o_fifo_valid, o_fifo_data, o_fifo_last, o_fifo_zlp} <= '0;
         hw_we <= 8'h00;
         hw_dat <= '0;
         ev_done <= '0;
         ev_ab <= 1'b0;
      end else begin
         hw_we <= 8'h00;
         ev_done <= '0;
         ev_ab <= 1'b0;
         if (ab_hit) begin
            ab_pend <= 1'b1;
            ab_ch <= i_rx_abort_ch;
            ab_addr <= i_rx_abort_sop;
         end
         case (st)
            utxd_pkg::S_IDLE: begin
               if (ab_pend) begin
                  ch <= ab_ch;
                  o_mem_addr <= ab_addr + utxd_pkg::DW_CTL;
                  o_mem_req <= 1'b1;
                  st <= utxd_pkg::S_ABRD;
               end else if (ports_on && rr_head != 32'h0) begin
                  ch <= rr;
                  cur_desc <= rr_head;
                  first <= 1'b1;
                  widx <= 2'h0;
                  o_mem_addr <= rr_head;
                  o_mem_req <= 1'b1;
                  st <= utxd_pkg::S_RD;
               end else begin
                  rr <= rr + utxd_chw_t'(1);
               end
            end
            utxd_pkg::S_RD: begin
               if (i_mem_ack) begin
                  o_mem_req <= 1'b0;
                  case (widx)
                     2'h0: d_next <= i_mem_rdata;
                     2'h1: d_buf <= i_mem_rdata;
                     2'h2: d_len <= i_mem_rdata;
                     default: d_ctl <= i_mem_rdata;
                  endcase
                  widx <= widx + 2'h1;
                  o_mem_addr <= o_mem_addr + 32'h4;
                  if (widx == 2'h3)
                     st <= utxd_pkg::S_EVAL;
               end else begin
                  o_mem_req <= 1'b1;
               end
            end
            utxd_pkg::S_EVAL: begin
               first <= 1'b0;
               hw_we[utxd_pkg::W_CDESC] <= 1'b1;
               hw_dat[utxd_pkg::W_CDESC] <= cur_desc;
               st <= utxd_pkg::S_BRD;
               if (first && !start_ok) begin
                  // not handed over yet: poll again later
                  rr <= rr + utxd_chw_t'(1);
                  st <= utxd_pkg::S_IDLE;
               end else if (first) begin
                  sop_ptr <= cur_desc;
                  sop_ctl <= d_ctl;
                  rem <= d_ctl[15:0];
                  act <= 16'h0;
                  hw_we[utxd_pkg::W_SOP] <= 1'b1;
                  hw_dat[utxd_pkg::W_SOP] <= cur_desc;
                  if (is_zlp) begin
                     buf_left <= 16'h0;
                     o_fifo_valid <= 1'b1;
                     o_fifo_zlp <= 1'b1;
                     o_fifo_last <= 1'b1;
                     o_fifo_data <= 8'h00;
                     st <= utxd_pkg::S_BOUT;
                  end else begin
                     buf_left <= sop_left;
                     cur_buf <= d_buf + {16'h0, d_len[31:16]};
                  end
               end else begin
                  buf_left <= d_len[15:0];
                  cur_buf <= d_buf;
               end
            end
            utxd_pkg::S_BRD: begin
               if (buf_done && pkt_end) begin
                  o_mem_we <= 1'b1;
                  o_mem_req <= 1'b1;
                  if (d_next == 32'h0) begin
                     o_mem_addr <= cur_desc + utxd_pkg::DW_CTL;
                     o_mem_wdata <= d_ctl | (32'h1 << utxd_pkg::EOQ_BIT);
                     st <= utxd_pkg::S_WEOQ;
                  end else begin
                     o_mem_addr <= sop_ptr + utxd_pkg::DW_CTL;
                     o_mem_wdata <= sop_ctl & ~(32'h1 << utxd_pkg::OWN_BIT);
                     st <= utxd_pkg::S_WOWN;
                  end
               end else if (buf_done) begin
                  cur_desc <= d_next;
                  o_mem_addr <= d_next;
                  o_mem_req <= 1'b1;
                  widx <= 2'h0;
                  st <= utxd_pkg::S_RD;
               end else if (i_mem_ack) begin
                  o_mem_req <= 1'b0;
                  o_fifo_data <= rd_byte;
                  o_fifo_valid <= 1'b1;
                  o_fifo_last <= (rem == 16'h1);
                  st <= utxd_pkg::S_BOUT;
               end else begin
                  o_mem_addr <= {cur_buf[31:2], 2'b00};
                  o_mem_req <= 1'b1;
               end
            end
            utxd_pkg::S_BOUT: begin
               if (i_fifo_ready) begin
                  o_fifo_valid <= 1'b0;
                  o_fifo_zlp <= 1'b0;
                  o_fifo_last <= 1'b0;
                  hw_we[utxd_pkg::W_LEN] <= 1'b1;
                  hw_we[utxd_pkg::W_CBUF] <= 1'b1;
                  hw_dat[utxd_pkg::W_CBUF] <= cur_buf;
                  if (o_fifo_zlp) begin
                     rem <= 16'h0;
                     hw_dat[utxd_pkg::W_LEN] <= {act, 16'h0};
                  end else begin
                     rem <= rem - 16'h1;
                     act <= act + 16'h1;
                     buf_left <= buf_left - 16'h1;
                     cur_buf <= cur_buf + 32'h1;
                     hw_dat[utxd_pkg::W_CBUF] <= cur_buf + 32'h1;
                     hw_dat[utxd_pkg::W_LEN] <= {act + 16'h1, rem - 16'h1};
                  end
                  st <= utxd_pkg::S_BRD;
               end
            end
            utxd_pkg::S_WEOQ: begin
               if (i_mem_ack) begin
                  o_mem_req <= 1'b0;
                  o_mem_addr <= sop_ptr + utxd_pkg::DW_CTL;
                  o_mem_wdata <= own_clr;
                  st <= utxd_pkg::S_WOWN;
               end else begin
                  o_mem_req <= 1'b1;
               end
            end
            utxd_pkg::S_WOWN: begin
               if (i_mem_ack) begin
                  o_mem_req <= 1'b0;
                  o_mem_we <= 1'b0;
                  st <= utxd_pkg::S_DONE;
               end else begin
                  o_mem_req <= 1'b1;
               end
            end
            utxd_pkg::S_DONE: begin
               hw_we[utxd_pkg::W_HEAD] <= 1'b1;
               hw_dat[utxd_pkg::W_HEAD] <= d_next;
               hw_we[utxd_pkg::W_COMP] <= 1'b1;
               hw_dat[utxd_pkg::W_COMP] <= cur_desc;
               ev_done[ch] <= 1'b1;
               st <= utxd_pkg::S_IDLE;
            end
            utxd_pkg::S_ABRD: begin
               if (i_mem_ack) begin
                  o_mem_req <= 1'b0;
                  o_mem_we <= 1'b1;
                  o_mem_wdata <= i_mem_rdata | (32'h1 << utxd_pkg::RXAB_BIT);
                  st <= utxd_pkg::S_ABWR;
               end else begin
                  o_mem_req <= 1'b1;
               end
            end
            utxd_pkg::S_ABWR: begin
               if (i_mem_ack) begin
                  o_mem_req <= 1'b0;
                  o_mem_we <= 1'b0;
                  hw_we[utxd_pkg::W_RECEIVE_BUFFER_COUNT] <= 1'b1;
                  hw_dat[utxd_pkg::W_RECEIVE_BUFFER_COUNT] <= 32'h0;
                  ev_ab <= 1'b1;
                  ab_pend <= 1'b0;
                  st <= utxd_pkg::S_IDLE;
               end else begin
                  o_mem_req <= 1'b1;
               end
            end
            default: st <= utxd_pkg::S_IDLE;
         endcase
      end
   end
endmodule : utxd_top
`default_nettype wire

// [testbench/utxd_checker.sv]
// port assertions for the transmit descriptor engine
`timescale 1ns/1ps
`default_nettype none
module utxd_checker (
   input wire logic i_clk, i_reset, i_wb_cyc, i_wb_stb, o_wb_ack, o_mem_req, o_mem_we, i_mem_ack,
   input wire logic [31:0] o_wb_dat, o_mem_addr, o_mem_wdata,
   input wire logic o_fifo_valid, o_fifo_last, o_fifo_zlp, i_fifo_ready,
   input wire logic [7:0] o_fifo_data,
   input wire logic [utxd_pkg::CHW-1:0] o_fifo_ch
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   chk_ack_next: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
      else $error("bus ack missing");
   chk_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
      else $error("bus ack too long");
   chk_dat_quiet: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
      else $error("read data outside ack");
   chk_mem_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr)
      && $stable(o_mem_we) && $stable(o_mem_wdata)) else $error("memory request moved");
   chk_mem_drop: assert property (o_mem_req && i_mem_ack |=> !o_mem_req)
      else $error("memory request kept");
   chk_fifo_hold: assert property (o_fifo_valid && !i_fifo_ready |=> o_fifo_valid
      && ($stable(o_fifo_data) || o_fifo_zlp) && $stable(o_fifo_last) && $stable(o_fifo_ch))
      else $error("fifo beat moved");
   chk_zlp_last: assert property (o_fifo_valid && o_fifo_zlp |-> o_fifo_last)
      else $error("zero byte beat not last");
   chk_eoq_end: assert property (o_mem_req && o_mem_we && o_mem_wdata[28] |-> o_mem_wdata[30])
      else $error("queue end flag off end descriptor");
endmodule : utxd_checker
bind utxd_top utxd_checker chk_u (.i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .o_wb_ack(o_wb_ack), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
   .i_mem_ack(i_mem_ack), .o_wb_dat(o_wb_dat), .o_mem_addr(o_mem_addr),
   .o_mem_wdata(o_mem_wdata), .o_fifo_valid(o_fifo_valid), .o_fifo_last(o_fifo_last),
   .o_fifo_zlp(o_fifo_zlp), .i_fifo_ready(i_fifo_ready), .o_fifo_data(o_fifo_data),
   .o_fifo_ch(o_fifo_ch));
`default_nettype wire

// [testbench/utxd_mem_model.sv]
// main memory model holding descriptor queues and buffers
`timescale 1ns/1ps
`default_nettype none
module utxd_mem_model (
   input wire logic i_clk, i_reset, i_req, i_we,
   input wire logic [31:0] i_addr, i_wdata,
   output logic o_ack,
   output logic [31:0] o_rdata
);
   logic [31:0] mem [0:255];
   logic [1:0] wait_cnt;
   logic slow;
   // answers alternate between prompt and slow; idle data keeps changing so no stale value helps
   always @(posedge i_clk) begin
      if (i_reset) begin
         o_ack <= 1'b0;
         wait_cnt <= 2'h0;
         slow <= 1'b0;
         o_rdata <= 32'h0;
      end else if (!o_ack && i_req && wait_cnt == (slow ? 2'h3 : 2'h0)) begin
         o_ack <= 1'b1;
         wait_cnt <= 2'h0;
         slow <= ~slow;
         if (i_we) mem[i_addr[9:2]] <= i_wdata;
         else o_rdata <= mem[i_addr[9:2]];
      end else begin
         o_ack <= 1'b0;
         o_rdata <= ~o_rdata;
         if (i_req && !o_ack) wait_cnt <= wait_cnt + 2'h1;
      end
   end
endmodule : utxd_mem_model
`default_nettype wire

// [testbench/usb_tx_descriptor_dma_bench.sv]
// self-checking bench for the transmit descriptor engine
`timescale 1ns/1ps
`default_nettype none
module usb_tx_descriptor_dma_bench;
   logic i_clk = 1'b0;
   logic rdy = 1'b0;
   logic i_reset, cyc, stb, we, ack, mreq, mwe, mack, fv, fl, fz, rxab, irq;
   logic [7:0] adr, fd;
   logic [31:0] wdat, rdat, wbd, maddr, mwd, mrd, sop;
   logic [1:0] fch, rxch;
   logic [3:0] rxen;
   logic [11:0] beats[$];
   int errors, n_compared;
   utxd_top dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_wb_cyc(cyc), .i_wb_stb(stb),
      .i_wb_we(we), .i_wb_adr(adr), .i_wb_dat(wdat), .i_wb_sel(4'hf), .o_wb_dat(wbd),
      .o_wb_ack(ack), .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_addr(maddr), .o_mem_wdata(mwd),
      .i_mem_ack(mack), .i_mem_rdata(mrd), .o_fifo_valid(fv), .o_fifo_data(fd), .o_fifo_last(fl),
      .o_fifo_zlp(fz), .o_fifo_ch(fch), .i_fifo_ready(rdy), .i_rx_abort(rxab),
      .i_rx_abort_ch(rxch), .i_rx_abort_sop(sop), .o_rx_enable(rxen), .o_irq(irq));
   utxd_mem_model mem_u (.i_clk(i_clk), .i_reset(i_reset), .i_req(mreq), .i_we(mwe),
      .i_addr(maddr), .i_wdata(mwd), .o_ack(mack), .o_rdata(mrd));
   always #12.5 i_clk = ~i_clk;
   // far side stalls every other cycle
   always @(posedge i_clk) rdy <= ~rdy;
   always @(posedge i_clk)
      if (fv === 1'b1 && rdy === 1'b1) beats.push_back({fch, fz, fl, fz ? 8'h0 : fd});
   task print_verdict;
      if (errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin @(posedge i_clk); n++; end while (ack !== 1'b1 && n < 20);
      rdat = wbd;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) chk(32'h1, 32'h0);
   endtask : wb
   task desc(input logic [31:0] a, nx, bp, w2, w3);
      mem_u.mem[a[9:2]] = nx;
      mem_u.mem[a[9:2] + 8'h1] = bp;
      mem_u.mem[a[9:2] + 8'h2] = w2;
      mem_u.mem[a[9:2] + 8'h3] = w3;
   endtask : desc
   task sc_regs;
      wb(1'b0, 8'h40, 32'h0); chk(rdat, 32'h0);
      wb(1'b1, 8'h80, 32'hff);
      wb(1'b0, 8'h80, 32'h0); chk(rdat, 32'h0);
      wb(1'b1, 8'h9c, 32'h5);
      wb(1'b0, 8'h9c, 32'h0); chk(rdat, 32'h0);
      wb(1'b1, 8'h50, 32'hcafe0001);
      wb(1'b0, 8'h50, 32'h0); chk(rdat, 32'hcafe0001);
   endtask : sc_regs
   task sc_queue;
      int n;
      logic [11:0] exp[6];
      exp = '{12'h822, 12'h933, 12'h855, 12'h866, 12'h977, 12'hb00};
      desc(32'h100, 32'h110, 32'h200, 32'h0001_0004, 32'he000_0002);
      desc(32'h110, 32'h120, 32'h210, 32'h1, 32'ha000_0003);
      desc(32'h120, 32'h130, 32'h214, 32'h1, 32'h0);
      desc(32'h130, 32'h140, 32'h218, 32'h1, 32'h4000_0000);
      desc(32'h140, 32'h0, 32'h220, 32'h1, 32'he080_0001);
      mem_u.mem[8'h80] = 32'h4433_2211;
      mem_u.mem[8'h84] = 32'h55;
      mem_u.mem[8'h85] = 32'h66;
      mem_u.mem[8'h86] = 32'h77;
      wb(1'b1, 8'h84, 32'h4);
      wb(1'b1, 8'h8c, 32'h1);
      wb(1'b1, 8'h40, 32'h100);
      n = 0;
      do begin wb(1'b0, 8'h40, 32'h0); n++; end while (rdat !== 32'h0 && n < 300);
      chk(rdat, 32'h0);
      chk(beats.size(), 6);
      foreach (exp[i]) if (i < beats.size()) chk(beats[i], exp[i]);
      chk(mem_u.mem[8'h43], 32'hc000_0002);
      chk(mem_u.mem[8'h47], 32'h8000_0003);
      chk(mem_u.mem[8'h4f], 32'h4000_0000);
      chk(mem_u.mem[8'h53], 32'hd080_0001);
      wb(1'b0, 8'h58, 32'h0); chk(rdat, 32'h140);
      chk(irq, 1'b1);
      wb(1'b1, 8'h58, 32'h140);
      chk(irq, 1'b0);
   endtask : sc_queue
   task sc_abort;
      int n;
      desc(32'h180, 32'h0, 32'h0, 32'h0, 32'h8a00_0010);
      wb(1'b1, 8'h3c, 32'h2);
      chk({28'h0, rxen}, 32'h2);
      @(posedge i_clk);
      rxch <= 2'h1;
      sop <= 32'h180;
      rxab <= 1'b1;
      @(posedge i_clk);
      rxab <= 1'b0;
      n = 0;
      do begin wb(1'b0, 8'h80, 32'h0); n++; end while (rdat[4] !== 1'b1 && n < 50);
      chk(mem_u.mem[8'h63], 32'h8a08_0010);
      wb(1'b0, 8'h3c, 32'h0); chk(rdat, 32'h0);
      chk({28'h0, rxen}, 32'h0);
      chk(irq, 1'b0);
      wb(1'b1, 8'h84, 32'h10);
      chk(irq, 1'b1);
      wb(1'b1, 8'h88, 32'h10);
      wb(1'b0, 8'h80, 32'h0); chk(rdat, 32'h0);
      chk(irq, 1'b0);
   endtask : sc_abort
   initial begin
      i_reset = 1'b1;
      {cyc, stb, we, rxab} = 4'h0;
      adr = 8'h0;
      wdat = 32'h0;
      rxch = 2'h0;
      sop = 32'h0;
      errors = 0;
      n_compared = 0;
      repeat (3) @(posedge i_clk);
      i_reset <= 1'b0;
      sc_regs;
      sc_queue;
      sc_abort;
      print_verdict;
   end
   // a hang is cut off well beyond the few hundred cycles the scenarios need
   initial begin
      repeat (20000) @(posedge i_clk);
      errors++;
      print_verdict;
   end
endmodule : usb_tx_descriptor_dma_bench
`default_nettype wire
